// *** asp_defines.vh ***
// Purpose: constants of the ascii parameter protocol interpreter
// Assumes: 8-bit ascii characters on the stream ports
// Notes:   definitions only
`ifndef ASP_DEFINES_VH
`define ASP_DEFINES_VH

// control characters
`define ASP_CH_STX    8'h02
`define ASP_CH_ETX    8'h03
`define ASP_CH_EOT    8'h04
`define ASP_CH_ENQ    8'h05
`define ASP_CH_ACK    8'h06
`define ASP_CH_BS     8'h08
`define ASP_CH_NAK    8'h15

// printable characters, and the high nibble shared by the digit characters
`define ASP_CH_ZERO   8'h30
`define ASP_CH_NINE   8'h39
`define ASP_CH_PLUS   8'h2b
`define ASP_CH_MINUS  8'h2d
`define ASP_DIGIT_HI  4'h3

// checksum lift out of the control range
`define ASP_BCC_MIN   8'h20
`define ASP_BCC_LIFT  8'h20

// protocol mode select value for the four-wire ascii protocol
`define ASP_MODE_ANSI 2'h1

// field sizes
`define ASP_ADDR_LAST 2'h3
`define ASP_ID_LEN    3'h4
`define ASP_DATA_MAX  3'h5

// reply character positions
`define ASP_IDX_ETX   4'ha
`define ASP_IDX_BCC   4'hb

`endif

// *** asp_serial_param.v ***
// Purpose: message-level interpreter for a multidrop ascii parameter protocol
// Assumes: characters arrive already framed by an external uart
// Notes:   parameter storage sits outside, reached through the par_ ports
`timescale 1ns/1ps
`default_nettype none
`include "asp_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - every message character, control or printable, is an ascii byte
// - reset character 04 opens every new host message
// - positive acknowledge is 06, negative acknowledge is 15
// - backspace 08 after a data reply reads the previous parameter
// - station address travels as four characters, each digit doubled
// - address characters follow the opening reset character directly
// - answer only our own station address, stay silent otherwise
// - parameter named by four digits, menu then parameter, no point
// - data field follows identifier, up to five characters, no point
// - bit parameters carried as 0 or 1 within five characters
// - commands and data replies end in one checksum character
// - read is reset, address, identifier, enquiry 05; device replies data
// - command uses start-of-text after address, then identifier and data
// - command closes with end-of-text 03 then the checksum
// - data reply is 02, identifier, five data, end-of-text, checksum
// - command answered by acknowledge if good, negative if bad
// - reads answered in every operating mode when configured
// - protocol active only while mode setting equals 1
// - checksum is xor of characters after start-of-text through end-of-text
// - checksum below 32 has 32 added
// - read of an unknown parameter is answered by reset character alone
// - command value outside parameter limits gets negative acknowledge
module asp_serial_param #(
  parameter CHAR_W = 8
) (
  input  wire              core_clk,
  input  wire              rstn,
  input  wire [1:0]        proto_mode,
  input  wire [7:0]        station_addr,
  input  wire [CHAR_W-1:0] rx_data,
  input  wire              rx_valid,
  output wire              rx_ready,
  output wire [CHAR_W-1:0] tx_data,
  output wire              tx_valid,
  input  wire              tx_ready,
  output wire              par_req,
  output wire              par_wr,
  output wire [31:0]       par_id,
  output wire [39:0]       par_wdata,
  output wire [2:0]        par_wlen,
  input  wire              par_done,
  input  wire              par_known,
  input  wire              par_in_range,
  input  wire [39:0]       par_rdata
);

  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_ID   = 7'h04;
  localparam [6:0] S_DATA = 7'h08;
  localparam [6:0] S_BCC  = 7'h10;
  localparam [6:0] S_PAR  = 7'h20;
  localparam [6:0] S_SEND = 7'h40;

  function [7:0] asp_fix;
    input [7:0] x;
    begin
      asp_fix = (x < `ASP_BCC_MIN) ? x + `ASP_BCC_LIFT : x;
    end
  endfunction

  reg [6:0]        state_reg;
  reg [6:0]        state_next;
  reg              rx_ready_reg;
  reg [1:0]        addr_cnt_reg;
  reg [2:0]        id_cnt_reg;
  reg [2:0]        data_cnt_reg;
  reg              is_cmd_reg;
  reg              err_reg;
  reg              last_valid_reg;
  reg [7:0]        bcc_reg;
  reg [31:0]       id_reg;
  reg [39:0]       wdata_reg;
  reg [39:0]       rdata_reg;
  reg              par_req_reg;
  reg              par_wr_reg;
  reg              reply_full_reg;
  reg [7:0]        reply_char_reg;
  reg [3:0]        tx_idx_reg;
  reg [7:0]        tx_bcc_reg;
  reg [CHAR_W-1:0] out_reg;
  reg              out_valid_reg;
  reg [CHAR_W-1:0] skid_reg;
  reg              skid_valid_reg;
  reg [7:0]        fill_char;

  wire       mode_on  = (proto_mode == `ASP_MODE_ANSI);
  wire       rx_take  = rx_valid & rx_ready_reg;
  wire [7:0] ch       = rx_data[7:0];
  wire       is_eot   = (ch == `ASP_CH_EOT);
  wire       is_digit = (ch >= `ASP_CH_ZERO) && (ch <= `ASP_CH_NINE);
  wire       is_sign  = (ch == `ASP_CH_PLUS) || (ch == `ASP_CH_MINUS);
  wire [7:0] addr_exp = addr_cnt_reg[1] ? {`ASP_DIGIT_HI, station_addr[3:0]}
                                        : {`ASP_DIGIT_HI, station_addr[7:4]};
  wire       bcc_bad  = (ch != asp_fix(bcc_reg ^ 8'h00));
  wire       fill_ok  = (state_reg == S_SEND) & ~skid_valid_reg;
  wire       tx_last  = reply_full_reg ? (tx_idx_reg == `ASP_IDX_BCC) : 1'b1;
  wire       pop      = out_valid_reg & tx_ready;
  wire [7:0] id_prev  = (id_reg[7:0] != `ASP_CH_ZERO) ? id_reg[7:0] - 8'h01
                                                      : `ASP_CH_NINE;

  assign rx_ready  = rx_ready_reg;
  assign tx_data   = out_reg;
  assign tx_valid  = out_valid_reg;
  assign par_req   = par_req_reg;
  assign par_wr    = par_wr_reg;
  assign par_id    = id_reg;
  assign par_wdata = wdata_reg;
  assign par_wlen  = data_cnt_reg;

  //////////////////////////////////////////////////////////////////////////////
  // message state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (rx_take && mode_on && is_eot) begin
          state_next = S_ADDR;
        end else if (rx_take && mode_on && ch == `ASP_CH_BS && last_valid_reg) begin
          state_next = S_PAR;
        end
      end
      S_ADDR: begin
        if (rx_take) begin
          if (is_eot) begin
            state_next = S_ADDR;
          end else if (ch != addr_exp) begin
            state_next = S_IDLE;
          end else if (addr_cnt_reg == `ASP_ADDR_LAST) begin
            state_next = S_ID;
          end
        end
      end
      S_ID: begin
        if (rx_take) begin
          if (is_eot) begin
            state_next = S_ADDR;
          end else if (!is_cmd_reg && ch == `ASP_CH_ENQ) begin
            state_next = (err_reg || id_cnt_reg != `ASP_ID_LEN) ? S_SEND : S_PAR;
          end else if (is_cmd_reg && ch == `ASP_CH_ETX) begin
            state_next = S_BCC;
          end else if (is_cmd_reg && is_digit && id_cnt_reg == 3'h3) begin
            state_next = S_DATA;
          end
        end
      end
      S_DATA: begin
        if (rx_take) begin
          if (is_eot) begin
            state_next = S_ADDR;
          end else if (ch == `ASP_CH_ETX) begin
            state_next = S_BCC;
          end
        end
      end
      S_BCC: begin
        if (rx_take) begin
          if (is_eot) begin
            state_next = S_ADDR;
          end else if (err_reg || bcc_bad || data_cnt_reg == 3'h0) begin
            state_next = S_SEND;
          end else begin
            state_next = S_PAR;
          end
        end
      end
      S_PAR: begin
        if (par_done) begin
          state_next = S_SEND;
        end
      end
      S_SEND: begin
        if (fill_ok && tx_last) begin
          state_next = S_IDLE;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive data path
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg      <= S_IDLE;
      rx_ready_reg   <= 1'b0;
      addr_cnt_reg   <= 2'h0;
      id_cnt_reg     <= 3'h0;
      data_cnt_reg   <= 3'h0;
      is_cmd_reg     <= 1'b0;
      err_reg        <= 1'b0;
      last_valid_reg <= 1'b0;
      bcc_reg        <= 8'h00;
      id_reg         <= 32'h0000_0000;
      wdata_reg      <= 40'h00_0000_0000;
      rdata_reg      <= 40'h00_0000_0000;
      par_req_reg    <= 1'b0;
      par_wr_reg     <= 1'b0;
      reply_full_reg <= 1'b0;
      reply_char_reg <= `ASP_CH_NAK;
    end else begin
      state_reg    <= state_next;
      rx_ready_reg <= (state_next != S_PAR) && (state_next != S_SEND);
      par_req_reg  <= (state_next == S_PAR) && (state_reg != S_PAR);
      par_wr_reg   <= (state_next == S_PAR) && (state_reg != S_IDLE) && is_cmd_reg;
      if (rx_take && is_eot) begin
        addr_cnt_reg   <= 2'h0;
        id_cnt_reg     <= 3'h0;
        data_cnt_reg   <= 3'h0;
        is_cmd_reg     <= 1'b0;
        err_reg        <= 1'b0;
        last_valid_reg <= 1'b0;
        bcc_reg        <= 8'h00;
        wdata_reg      <= 40'h00_0000_0000;
      end else if (rx_take) begin
        case (state_reg)
          S_IDLE: begin
            if (state_next == S_PAR) begin
              // previous parameter number, decimal borrow into the tens digit
              id_reg[7:0] <= id_prev;
              if (id_reg[7:0] == `ASP_CH_ZERO) begin
                id_reg[15:8] <= (id_reg[15:8] != `ASP_CH_ZERO) ? id_reg[15:8] - 8'h01
                                                               : `ASP_CH_ZERO;
                if (id_reg[15:8] == `ASP_CH_ZERO) begin
                  id_reg[7:0] <= `ASP_CH_ZERO;
                end
              end
            end
          end
          S_ADDR: begin
            addr_cnt_reg <= addr_cnt_reg + 2'h1;
          end
          S_ID: begin
            if (ch == `ASP_CH_STX && id_cnt_reg == 3'h0 && !is_cmd_reg) begin
              is_cmd_reg <= 1'b1;
            end else if (is_digit && id_cnt_reg != `ASP_ID_LEN) begin
              id_reg     <= {id_reg[23:0], ch};
              id_cnt_reg <= id_cnt_reg + 3'h1;
              if (is_cmd_reg) begin
                bcc_reg <= bcc_reg ^ ch;
              end
            end else if (!(ch == `ASP_CH_ENQ && !is_cmd_reg)) begin
              // short identifier or stray character spoils the message
              err_reg <= 1'b1;
              if (is_cmd_reg) begin
                bcc_reg <= bcc_reg ^ ch;
              end
            end
            if (state_next == S_SEND) begin
              reply_full_reg <= 1'b0;
              reply_char_reg <= `ASP_CH_NAK;
            end
          end
          S_DATA: begin
            bcc_reg <= bcc_reg ^ ch;
            if (ch != `ASP_CH_ETX) begin
              if (data_cnt_reg == `ASP_DATA_MAX || !(is_digit || is_sign)) begin
                err_reg <= 1'b1;
              end else begin
                wdata_reg    <= {wdata_reg[31:0], ch};
                data_cnt_reg <= data_cnt_reg + 3'h1;
              end
            end
          end
          S_BCC: begin
            reply_full_reg <= 1'b0;
            reply_char_reg <= `ASP_CH_NAK;
          end
          default: begin
            err_reg <= err_reg;
          end
        endcase
      end
      if (state_reg == S_PAR && par_done) begin
        rdata_reg <= par_rdata;
        if (is_cmd_reg) begin
          reply_full_reg <= 1'b0;
          reply_char_reg <= (par_known && par_in_range) ? `ASP_CH_ACK : `ASP_CH_NAK;
        end else begin
          reply_full_reg <= par_known;
          reply_char_reg <= `ASP_CH_EOT;
        end
      end
      if (state_reg == S_SEND && state_next == S_IDLE) begin
        last_valid_reg <= reply_full_reg;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // reply sequencer
  always @* begin
    fill_char = reply_char_reg;
    if (reply_full_reg) begin
      case (tx_idx_reg)
        4'h0: fill_char = `ASP_CH_STX;
        4'h1: fill_char = id_reg[31:24];
        4'h2: fill_char = id_reg[23:16];
        4'h3: fill_char = id_reg[15:8];
        4'h4: fill_char = id_reg[7:0];
        4'h5: fill_char = rdata_reg[39:32];
        4'h6: fill_char = rdata_reg[31:24];
        4'h7: fill_char = rdata_reg[23:16];
        4'h8: fill_char = rdata_reg[15:8];
        4'h9: fill_char = rdata_reg[7:0];
        4'ha: fill_char = `ASP_CH_ETX;
        default: fill_char = asp_fix(tx_bcc_reg);
      endcase
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_idx_reg <= 4'h0;
      tx_bcc_reg <= 8'h00;
    end else if (state_reg != S_SEND) begin
      tx_idx_reg <= 4'h0;
      tx_bcc_reg <= 8'h00;
    end else if (fill_ok) begin
      tx_idx_reg <= tx_idx_reg + 4'h1;
      if (tx_idx_reg != 4'h0 && tx_idx_reg <= `ASP_IDX_ETX) begin
        tx_bcc_reg <= tx_bcc_reg ^ fill_char;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // two-entry output buffer: a stalled receiver fills the skid slot, which
  // then holds the sequencer until the head drains
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      out_reg        <= {CHAR_W{1'b0}};
      out_valid_reg  <= 1'b0;
      skid_reg       <= {CHAR_W{1'b0}};
      skid_valid_reg <= 1'b0;
    end else if (!out_valid_reg || pop) begin
      if (skid_valid_reg) begin
        out_reg        <= skid_reg;
        out_valid_reg  <= 1'b1;
        skid_valid_reg <= 1'b0;
      end else begin
        out_reg       <= fill_char[CHAR_W-1:0];
        out_valid_reg <= fill_ok;
      end
    end else if (fill_ok) begin
      skid_reg       <= fill_char[CHAR_W-1:0];
      skid_valid_reg <= 1'b1;
    end
  end

endmodule // asp_serial_param
`default_nettype wire

// *** asp_checker_properties.sv ***
// Purpose: port-level properties of the ascii parameter interpreter
// Assumes: one clock domain, reset rstn active low
// Notes:   attached by bind from tb_top
`timescale 1ns/1ps
`default_nettype none
module asp_checker #(
  parameter CHAR_W = 8
) (
  input wire logic              core_clk,
  input wire logic              rstn,
  input wire logic [1:0]        proto_mode,
  input wire logic [7:0]        station_addr,
  input wire logic [CHAR_W-1:0] rx_data,
  input wire logic              rx_valid,
  input wire logic              rx_ready,
  input wire logic [CHAR_W-1:0] tx_data,
  input wire logic              tx_valid,
  input wire logic              tx_ready,
  input wire logic              par_req,
  input wire logic              par_wr,
  input wire logic [31:0]       par_id,
  input wire logic [39:0]       par_wdata,
  input wire logic [2:0]        par_wlen,
  input wire logic              par_done,
  input wire logic              par_known,
  input wire logic              par_in_range,
  input wire logic [39:0]       par_rdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  // every identifier character must be a decimal digit
  wire id_ok = par_id[31:28] == 4'h3 && par_id[27:24] < 4'ha &&
               par_id[23:20] == 4'h3 && par_id[19:16] < 4'ha &&
               par_id[15:12] == 4'h3 && par_id[11:8] < 4'ha &&
               par_id[7:4] == 4'h3 && par_id[3:0] < 4'ha;
  property p_req_pulse;
    par_req |=> !par_req;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("long par_req");
  property p_req_busy;
    par_req |-> !rx_ready;
  endproperty
  a_req_busy: assert property (p_req_busy) else $error("rx open while busy");
  property p_req_cause;
    par_req |-> $past(rx_valid && rx_ready);
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("par_req without char");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("reply char dropped");
  property p_ascii;
    tx_valid |-> !tx_data[7];
  endproperty
  a_ascii: assert property (p_ascii) else $error("reply char not ascii");
  property p_codes;
    tx_valid && tx_data < 8'h20 |-> tx_data inside {8'h02, 8'h03, 8'h04, 8'h06, 8'h15};
  endproperty
  a_codes: assert property (p_codes) else $error("bad control char");
  property p_wlen;
    par_req && par_wr |-> par_wlen inside {[3'h1:3'h5]};
  endproperty
  a_wlen: assert property (p_wlen) else $error("bad data length");
  property p_id;
    par_req |-> id_ok;
  endproperty
  a_id: assert property (p_id) else $error("identifier not digits");
  property p_done_tx;
    par_done |-> ##[1:4] tx_valid;
  endproperty
  a_done_tx: assert property (p_done_tx) else $error("no answer after done");
  c_read: cover property (par_req && !par_wr);
  c_write: cover property (par_req && par_wr);
  c_stall: cover property (tx_valid && !tx_ready);
endmodule // asp_checker
`default_nettype wire

// *** asp_host_model.sv ***
// Purpose: host side of the character link
// Assumes: tb fills send_q and reads got_q
// Notes:   slow takes one reply char in eight
`timescale 1ns/1ps
`default_nettype none
module asp_host_model (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       slow,
  output var  logic [7:0] rx_data,
  output var  logic       rx_valid,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output var  logic       tx_ready
);
  logic [7:0] send_q[$];
  logic [7:0] got_q[$];
  logic [2:0] slot_reg;
  ////////////////////////////////////////
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_data <= 8'hff;
      rx_valid <= 1'b0;
      tx_ready <= 1'b0;
      slot_reg <= 3'h0;
    end else begin
      slot_reg <= slot_reg + 3'h1;
      if (tx_valid && tx_ready) begin
        got_q.push_back(tx_data);
      end
      tx_ready <= !slow || slot_reg == 3'h0;
      // a char is held until taken; bytes only, so any 8-bit value is passed on as sent
      if (!rx_valid || rx_ready) begin
        if (send_q.size() > 0) begin
          rx_valid <= 1'b1;
          rx_data <= send_q.pop_front();
        end else begin
          rx_valid <= 1'b0;
          // idle line must not keep looking like the last char
          rx_data <= ~rx_data;
        end
      end
    end
  end
endmodule // asp_host_model
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench of the ascii parameter interpreter
// Assumes: station 12, storage answers -0476 to every read
// Notes:   identifier 1723 unknown, data ending in 9 out of range
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [1:0]  mode = 2'h1;
  logic        slow = 1'b0;
  logic [7:0]  rx_data, tx_data;
  logic        rx_valid, rx_ready, tx_valid, tx_ready;
  logic        par_req, par_wr;
  logic        par_done = 1'b0;
  logic        wr_seen = 1'b0;
  logic [31:0] par_id;
  logic [39:0] par_wdata;
  logic [2:0]  par_wlen;
  int          lat = 1, wait_reg = 0, cyc_reg = 0;
  int          n_mismatch = 0, total_checks = 0;
  wire         par_known = par_id != 32'h31373233;
  wire         par_in_range = par_wdata[7:0] != 8'h39;
  initial forever #4 core_clk = ~core_clk;
  asp_serial_param DUT (.core_clk(core_clk), .rstn(rstn), .proto_mode(mode),
    .station_addr(8'h12), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .par_req(par_req),
    .par_wr(par_wr), .par_id(par_id), .par_wdata(par_wdata), .par_wlen(par_wlen),
    .par_done(par_done), .par_known(par_known), .par_in_range(par_in_range),
    .par_rdata(40'h2d30343736));
  asp_host_model hm (.core_clk(core_clk), .rstn(rstn), .slow(slow), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready));
  ////////////////////////////////////////
  always @(posedge core_clk) begin
    cyc_reg <= cyc_reg + 1;
    par_done <= 1'b0;
    if (par_req) begin
      wait_reg <= lat;
      wr_seen <= par_wr;
    end else if (wait_reg == 1) begin
      par_done <= 1'b1;
      wait_reg <= 0;
    end else if (wait_reg > 1) begin
      wait_reg <= wait_reg - 1;
    end
  end
  task automatic check(logic [39:0] seen, logic [39:0] exp, string what);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s saw %h want %h", $time, what, seen, exp);
    end
  endtask
  // checksum over everything after the first start-of-text
  function automatic string cks(string s);
    logic [7:0] x;
    int         i, go;
    x = 8'h00;
    go = 0;
    for (i = 0; i < s.len(); i++) begin
      if (go) x ^= s[i];
      if (s[i] == 8'h02) go = 1;
    end
    if (x < 8'h20) x += 8'h20;
    return $sformatf("%s%c", s, x);
  endfunction
  task automatic xfer(string m, string e, string what);
    int i;
    hm.got_q.delete();
    for (i = 0; i < m.len(); i++) hm.send_q.push_back(m[i]);
    i = 0;
    while (i < 600 && (hm.send_q.size() > 0 || hm.got_q.size() < e.len())) begin
      @(posedge core_clk);
      i++;
    end
    repeat (40) @(posedge core_clk);
    check(40'(hm.got_q.size()), 40'(e.len()), {what, " count"});
    for (i = 0; i < e.len() && i < hm.got_q.size(); i++) begin
      check(hm.got_q[i], e[i], what);
    end
  endtask
  task automatic t_read();
    xfer("\00411220117\005", cks("\0020117-0476\003"), "read");
    slow <= 1'b1;
    lat <= 6;
    xfer("\00411220117\005", cks("\0020117-0476\003"), "stall");
    xfer("\010", cks("\0020116-0476\003"), "back");
    check(par_id, 32'h30313136, "back id");
    check(wr_seen, 1'b0, "read wr");
    slow <= 1'b0;
    lat <= 1;
    xfer("\00411221723\005", "\004", "unknown");
    xfer("\010", "", "no back");
    xfer("\00411220110\005", cks("\0020110-0476\003"), "ten");
    xfer("\010", cks("\0020109-0476\003"), "borrow");
    $display("test read done");
  endtask
  task automatic t_cmd();
    xfer(cks("\0041122\0020117-0476\003"), "\006", "cmd");
    xfer(cks("\0041122\002011744\003"), "\006", "lift");
    check(par_id, 32'h30313137, "cmd id");
    check(par_wdata, 40'h3434, "cmd data");
    check(par_wlen, 3'h2, "cmd len");
    check(wr_seen, 1'b1, "cmd wr");
    $display("test command done");
  endtask
  task automatic t_bad();
    xfer("\0041122\0020117-0476\003X", "\025", "bcc");
    xfer(cks("\0041122\00201179\003"), "\025", "limit");
    xfer(cks("\0041122\0020117123456\003"), "\025", "long");
    xfer(cks("\0041122\00201174.7\003"), "\025", "point");
    xfer("\0041122011\005", "\025", "short");
    xfer(cks("\0041122\0020117\003"), "\025", "empty");
    $display("test bad done");
  endtask
  task automatic t_addr();
    xfer("\00433440117\005", "", "other");
    xfer("\00412220117\005", "", "undoubled");
    xfer("\0041122011\00411220117\005", cks("\0020117-0476\003"), "abort");
    $display("test address done");
  endtask
  task automatic t_mode();
    mode <= 2'h0;
    xfer("\00411220117\005", "", "mode0");
    mode <= 2'h3;
    xfer("\00411220117\005", "", "mode3");
    mode <= 2'h1;
    xfer("\00411220117\005", cks("\0020117-0476\003"), "mode1");
    $display("test mode done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    wait (cyc_reg == 20000);
    n_mismatch++;
    $display("unexpected at %0t: run timed out", $time);
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(rx_ready, 1'b1, "ready after reset");
    check(tx_valid, 1'b0, "idle after reset");
    t_read();
    t_cmd();
    t_bad();
    t_addr();
    t_mode();
    print_verdict();
  end
endmodule // tb_top
bind asp_serial_param asp_checker #(.CHAR_W(CHAR_W)) u_chk (.core_clk(core_clk),
  .rstn(rstn), .proto_mode(proto_mode), .station_addr(station_addr), .rx_data(rx_data),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .par_req(par_req), .par_wr(par_wr), .par_id(par_id),
  .par_wdata(par_wdata), .par_wlen(par_wlen), .par_done(par_done),
  .par_known(par_known), .par_in_range(par_in_range), .par_rdata(par_rdata));
`default_nettype wire
